// ---- design/dumc_regs.svh ----
// register map, field layout and reset constants for the update-mode block
// Summary of operation
// [RULE_01] every converter starts in immediate update mode after reset
// [RULE_02] a one in timed-select bit n puts converter n in timed mode
// [RULE_03] a one in immediate-select bit n puts converter n in immediate mode
// [RULE_04] a zero in either select register leaves that converter's mode alone
// [RULE_05] software writes zeros to all reserved upper bits
// [RULE_06] deferred-mode bit one enrolls converter n, zero removes it
// [RULE_07] deferred converters take every update pulse while timed-select is set
// [RULE_08] deferred converters hold new values until the pulse, moving together
// [RULE_09] the waveform clear strobe leaves deferred membership untouched
// [RULE_10] each sequence write enrolls the converter numbered in bits 2 to 0; the code drops writes once eight entries are held
// [RULE_11] waveform samples reach converters in the order they were written
// [RULE_12] with misc bit 1 set, programmable-full flag raises an interrupt
// [RULE_13] software answers that interrupt by feeding more samples to the fifo
// [RULE_14] misc bit 0 masks the update pulse to all sequence-enrolled converters
// [RULE_15] software issues the clear strobe after each waveform operation
// [RULE_16] immediate converters change on write, timed ones only on a pulse
// [RULE_17] a direct data write loads its converter without using the fifo
// [RULE_18] direct data is twelve-bit straight binary in bits 11 to 0
`ifndef DUMC_REGS_SVH
`define DUMC_REGS_SVH
`define DUMC_APB_AW 8
`define DUMC_IDX_W 6
`define DUMC_IDX_DIRECT_HI 3'h0
`define DUMC_IDX_TIMED 6'h10
`define DUMC_IDX_IMMED 6'h11
`define DUMC_IDX_DEFER 6'h14
`define DUMC_IDX_WAVE 6'h15
`define DUMC_IDX_MISC 6'h16
`define DUMC_IDX_STATUS 6'h20
`define DUMC_IDX_IRQ_ST 6'h21
`define DUMC_IDX_IRQ_MASK 6'h22
`define DUMC_NUM_DAC 8
`define DUMC_DAC_W 12
`define DUMC_SEQ_DEPTH 8
`define DUMC_MODE_MSB 7
`define DUMC_WAVE_NUM_MSB 2
`define DUMC_DATA_MSB 11
`define DUMC_MISC_CLR_BIT 0
`define DUMC_MISC_PFF_EN_BIT 1
`define DUMC_ST_TIMED_LSB 0
`define DUMC_ST_DEFER_LSB 8
`define DUMC_ST_ENROL_LSB 16
`define DUMC_ST_COUNT_LSB 24
`define DUMC_ST_PFF_BIT 28
`define DUMC_IRQ_W 3
`define DUMC_IRQ_PFF_BIT 0
`define DUMC_IRQ_OVF_BIT 1
`define DUMC_IRQ_UPD_BIT 2
`define DUMC_TIMED_RST 8'h00
`define DUMC_DEFER_RST 8'h00
`define DUMC_ENROL_RST 8'h00
`define DUMC_MASK_RST 3'h1
`define DUMC_DAC_RST 12'h000
`endif

// ---- design/dumc_pkg.sv ----
// types shared by the update-mode block
`include "dumc_regs.svh"
package dumc_pkg;
	typedef logic [`DUMC_DAC_W-1:0] dumc_dac_t;
	typedef logic [`DUMC_WAVE_NUM_MSB:0] dumc_num_t;
	typedef logic [`DUMC_MODE_MSB:0] dumc_mask_t;
	typedef enum {
		DUMC_REG_NONE,
		DUMC_REG_DIRECT,
		DUMC_REG_TIMED,
		DUMC_REG_IMMED,
		DUMC_REG_DEFER,
		DUMC_REG_WAVE,
		DUMC_REG_MISC,
		DUMC_REG_STATUS,
		DUMC_REG_IRQ_ST,
		DUMC_REG_IRQ_MASK
	} dumc_reg_e;
endpackage : dumc_pkg

// ---- design/dumc_seq_if.sv ----
// sequence memory port between controller and storage
`timescale 1ns/1ps
interface dumc_seq_if #(parameter int PTR_W = 3);
	logic wr_en;
	logic [PTR_W-1:0] wr_addr;
	logic [2:0] wr_num;
	logic [PTR_W-1:0] rd_addr;
	logic [2:0] rd_num;
	modport ctrl (output wr_en, output wr_addr, output wr_num,
		output rd_addr, input rd_num);
	modport mem (input wr_en, input wr_addr, input wr_num,
		input rd_addr, output rd_num);
endinterface : dumc_seq_if

// ---- design/dumc_seq_mem.sv ----
// ordered list of converter numbers for waveform generation
`timescale 1ns/1ps
`include "dumc_regs.svh"
module dumc_seq_mem import dumc_pkg::*; #(
	parameter int DEPTH = `DUMC_SEQ_DEPTH,
	parameter int PTR_W = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	dumc_seq_if.mem seq
);
	dumc_num_t mem_r [DEPTH];
	dumc_num_t mem_nxt [DEPTH];
	dumc_num_t rd_r;
	dumc_num_t rd_nxt;

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_nxt[i] = mem_r[i];
			if (seq.wr_en && (int'(seq.wr_addr) == i)) begin
				mem_nxt[i] = seq.wr_num;
			end
		end
		// registered read: old entry if read and write meet
		rd_nxt = mem_r[seq.rd_addr];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= 3'h0;
			end
			rd_r <= 3'h0;
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= mem_nxt[i];
			end
			rd_r <= rd_nxt;
		end
	end

	assign seq.rd_num = rd_r;
endmodule : dumc_seq_mem

// ---- design/dumc_update_ctrl.sv ----
// converter update-mode control with apb registers and waveform sequencing
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "dumc_regs.svh"
module dumc_update_ctrl import dumc_pkg::*; #(
	parameter int SEQ_DEPTH = `DUMC_SEQ_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`DUMC_APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic update_pulse,
	input wire logic fifo_prog_full_flag,
	input wire logic wave_valid,
	input wire logic [`DUMC_DAC_W-1:0] wave_data,
	output logic wave_ready,
	output logic [`DUMC_NUM_DAC*`DUMC_DAC_W-1:0] dac_value,
	output logic [`DUMC_NUM_DAC-1:0] dac_timed,
	output logic irq
);
	localparam int NDAC = `DUMC_NUM_DAC;
	localparam int PTR_W = (SEQ_DEPTH > 1) ? $clog2(SEQ_DEPTH) : 1;
	localparam int CNT_W = $clog2(SEQ_DEPTH + 1);

	// bus side
	logic [`DUMC_IDX_W-1:0] idx;
	dumc_reg_e reg_sel;
	logic setup;
	logic wr;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;

	// mode and enrollment state
	dumc_mask_t timed_r;
	dumc_mask_t timed_nxt;
	dumc_mask_t defer_r;
	dumc_mask_t defer_nxt;
	dumc_mask_t enrol_r;
	dumc_mask_t enrol_nxt;
	logic pff_en_r;
	logic pff_en_nxt;

	// sequence state
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [PTR_W-1:0] ptr_r;
	logic [PTR_W-1:0] ptr_nxt;
	logic [CNT_W-1:0] ptr_inc;
	logic wave_ready_r;
	logic wave_ready_nxt;
	logic seq_wr;
	logic seq_full;
	logic wg_clr;
	logic wave_acc;

	// converter data
	dumc_dac_t pend_r [NDAC];
	dumc_dac_t pend_nxt [NDAC];
	dumc_dac_t out_r [NDAC];
	dumc_dac_t out_nxt [NDAC];
	dumc_mask_t upd_hit;

	// interrupt state
	logic [`DUMC_IRQ_W-1:0] irqst_r;
	logic [`DUMC_IRQ_W-1:0] irqst_nxt;
	logic [`DUMC_IRQ_W-1:0] irq_set;
	logic [`DUMC_IRQ_W-1:0] irq_clr;
	logic [`DUMC_IRQ_W-1:0] mask_r;
	logic [`DUMC_IRQ_W-1:0] mask_nxt;
	logic irq_r;
	logic irq_nxt;

	dumc_seq_if #(.PTR_W(PTR_W)) seq ();

	dumc_seq_mem #(
		.DEPTH(SEQ_DEPTH),
		.PTR_W(PTR_W)
	) u_seq_mem (
		.pclk(pclk),
		.presetn(presetn),
		.seq(seq)
	);

	assign idx = paddr[`DUMC_IDX_W+1:2];

	always_comb begin
		reg_sel = DUMC_REG_NONE;
		if (paddr[1:0] == 2'b00) begin
			if (idx[`DUMC_IDX_W-1:3] == `DUMC_IDX_DIRECT_HI) begin
				reg_sel = DUMC_REG_DIRECT;
			end else begin
				case (idx)
					`DUMC_IDX_TIMED: reg_sel = DUMC_REG_TIMED;
					`DUMC_IDX_IMMED: reg_sel = DUMC_REG_IMMED;
					`DUMC_IDX_DEFER: reg_sel = DUMC_REG_DEFER;
					`DUMC_IDX_WAVE: reg_sel = DUMC_REG_WAVE;
					`DUMC_IDX_MISC: reg_sel = DUMC_REG_MISC;
					`DUMC_IDX_STATUS: reg_sel = DUMC_REG_STATUS;
					`DUMC_IDX_IRQ_ST: reg_sel = DUMC_REG_IRQ_ST;
					`DUMC_IDX_IRQ_MASK: reg_sel = DUMC_REG_IRQ_MASK;
					default: reg_sel = DUMC_REG_NONE;
				endcase
			end
		end
	end

	// answer is prepared in setup so every bus output is a flop
	assign setup = psel && !penable;
	assign wr = psel && penable && pready_r && pwrite;

	always_comb begin
		pready_nxt = setup;
		pslverr_nxt = setup && (reg_sel == DUMC_REG_NONE);
		prdata_nxt = 32'h0000_0000;
		if (setup && !pwrite) begin
			case (reg_sel)
				DUMC_REG_STATUS: begin
					prdata_nxt[`DUMC_ST_TIMED_LSB +: 8] = timed_r;
					prdata_nxt[`DUMC_ST_DEFER_LSB +: 8] = defer_r;
					prdata_nxt[`DUMC_ST_ENROL_LSB +: 8] = enrol_r;
					prdata_nxt[`DUMC_ST_COUNT_LSB +: 4] = 4'(cnt_r);
					prdata_nxt[`DUMC_ST_PFF_BIT] = fifo_prog_full_flag;
				end
				DUMC_REG_IRQ_ST: begin
					prdata_nxt[`DUMC_IRQ_W-1:0] = irqst_r;
				end
				DUMC_REG_IRQ_MASK: begin
					prdata_nxt[`DUMC_IRQ_W-1:0] = mask_r;
				end
				default: begin
					// write-only registers read as zero
					prdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	// reserved upper bits are simply not looked at
	always_comb begin
		timed_nxt = timed_r;
		defer_nxt = defer_r;
		pff_en_nxt = pff_en_r;
		mask_nxt = mask_r;
		if (wr) begin
			case (reg_sel)
				DUMC_REG_TIMED: begin
					timed_nxt = timed_r | pwdata[`DUMC_MODE_MSB:0]; // see [RULE_02] [RULE_04]
				end
				DUMC_REG_IMMED: begin
					timed_nxt = timed_r & ~pwdata[`DUMC_MODE_MSB:0]; // see [RULE_03] [RULE_04]
				end
				DUMC_REG_DEFER: begin
					defer_nxt = pwdata[`DUMC_MODE_MSB:0]; // see [RULE_06]
				end
				DUMC_REG_MISC: begin
					pff_en_nxt = pwdata[`DUMC_MISC_PFF_EN_BIT]; // see [RULE_12]
				end
				DUMC_REG_IRQ_MASK: begin
					mask_nxt = pwdata[`DUMC_IRQ_W-1:0];
				end
				default: begin
					timed_nxt = timed_r;
				end
			endcase
		end
	end

	// sequence list: append on write, walk cyclically per sample
	assign seq_full = (cnt_r == CNT_W'(SEQ_DEPTH));
	assign seq_wr = wr && (reg_sel == DUMC_REG_WAVE);
	assign wg_clr = wr && (reg_sel == DUMC_REG_MISC) &&
		pwdata[`DUMC_MISC_CLR_BIT];
	assign wave_acc = wave_valid && wave_ready_r;
	assign ptr_inc = CNT_W'(ptr_r) + CNT_W'(1);

	assign seq.wr_en = seq_wr && !seq_full; // see [RULE_10] [RULE_11]
	assign seq.wr_addr = cnt_r[PTR_W-1:0];
	assign seq.wr_num = pwdata[`DUMC_WAVE_NUM_MSB:0];
	assign seq.rd_addr = ptr_r;

	always_comb begin
		cnt_nxt = cnt_r;
		ptr_nxt = ptr_r;
		enrol_nxt = enrol_r;
		if (seq.wr_en) begin
			cnt_nxt = cnt_r + CNT_W'(1);
			enrol_nxt[seq.wr_num] = 1'b1; // see [RULE_10]
		end
		if (wave_acc) begin
			// first written is first served, then wrap round
			if (ptr_inc >= cnt_r) begin // see [RULE_11]
				ptr_nxt = '0;
			end else begin
				ptr_nxt = ptr_inc[PTR_W-1:0];
			end
		end
		// deferred membership lives apart and survives this
		if (wg_clr) begin // see [RULE_14] [RULE_09]
			cnt_nxt = '0;
			ptr_nxt = '0;
			enrol_nxt = `DUMC_ENROL_RST;
		end
		// one bubble after each sample lets the list read settle;
		// costs half the sample rate, saves a bypass path
		wave_ready_nxt = (cnt_r != '0) && !wave_acc && !wg_clr;
	end

	always_comb begin
		upd_hit = '0;
		for (int n = 0; n < NDAC; n++) begin
			pend_nxt[n] = pend_r[n];
			out_nxt[n] = out_r[n];
			// deferred timed converters take every pulse; sequence members only
			// until the clear strobe drops them
			if (update_pulse && timed_r[n] &&
				(defer_r[n] || enrol_r[n])) begin // see [RULE_07] [RULE_14]
				out_nxt[n] = pend_r[n]; // see [RULE_08] [RULE_16]
				upd_hit[n] = 1'b1;
			end
			if (wave_acc && (int'(seq.rd_num) == n)) begin // see [RULE_11]
				pend_nxt[n] = wave_data;
				if (!timed_r[n]) begin
					out_nxt[n] = wave_data; // see [RULE_16]
				end
			end
			// direct write last: it wins over a sample in the same cycle
			if (wr && (reg_sel == DUMC_REG_DIRECT) &&
				(int'(idx[2:0]) == n)) begin // see [RULE_17]
				pend_nxt[n] = pwdata[`DUMC_DATA_MSB:0]; // see [RULE_18]
				if (!timed_r[n]) begin
					out_nxt[n] = pwdata[`DUMC_DATA_MSB:0]; // see [RULE_16]
				end
			end
		end
	end

	// sticky events, set beats a same-cycle clear
	always_comb begin
		irq_set = '0;
		irq_set[`DUMC_IRQ_PFF_BIT] = fifo_prog_full_flag && pff_en_r; // see [RULE_12]
		irq_set[`DUMC_IRQ_OVF_BIT] = seq_wr && seq_full;
		irq_set[`DUMC_IRQ_UPD_BIT] = |upd_hit;
		irq_clr = '0;
		if (wr && (reg_sel == DUMC_REG_IRQ_ST)) begin
			irq_clr = pwdata[`DUMC_IRQ_W-1:0];
		end
		irqst_nxt = (irqst_r & ~irq_clr) | irq_set;
		irq_nxt = |(irqst_nxt & mask_nxt); // see [RULE_12]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timed_r <= `DUMC_TIMED_RST; // see [RULE_01]
			defer_r <= `DUMC_DEFER_RST;
			pff_en_r <= 1'b0;
			mask_r <= `DUMC_MASK_RST;
		end else begin
			timed_r <= timed_nxt;
			defer_r <= defer_nxt;
			pff_en_r <= pff_en_nxt;
			mask_r <= mask_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			ptr_r <= '0;
			enrol_r <= `DUMC_ENROL_RST;
			wave_ready_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			ptr_r <= ptr_nxt;
			enrol_r <= enrol_nxt;
			wave_ready_r <= wave_ready_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int n = 0; n < NDAC; n++) begin
				pend_r[n] <= `DUMC_DAC_RST;
				out_r[n] <= `DUMC_DAC_RST;
			end
		end else begin
			for (int n = 0; n < NDAC; n++) begin
				pend_r[n] <= pend_nxt[n];
				out_r[n] <= out_nxt[n];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irqst_r <= '0;
			irq_r <= 1'b0;
		end else begin
			irqst_r <= irqst_nxt;
			irq_r <= irq_nxt;
		end
	end

	always_comb begin
		for (int n = 0; n < NDAC; n++) begin
			dac_value[n*`DUMC_DAC_W +: `DUMC_DAC_W] = out_r[n];
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign wave_ready = wave_ready_r;
	assign dac_timed = timed_r;
	assign irq = irq_r;
endmodule : dumc_update_ctrl

// ---- verification/dumc_properties.sv ----
// port assertions for the update-mode block
`timescale 1ns/1ps
module dumc_properties import dumc_pkg::*; #(
	parameter int SEQ_DEPTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic update_pulse,
	input wire logic fifo_prog_full_flag,
	input wire logic wave_valid,
	input wire logic wave_ready,
	input wire logic [95:0] dac_value,
	input wire logic [7:0] dac_timed,
	input wire logic irq
);
	logic wr;
	logic cause;
	assign wr = psel && penable && pwrite && pready;
	// irq is registered on the same edge as status, from the next status value; look back up to three edges
	assign cause = fifo_prog_full_flag || update_pulse || wr;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	rdy_zero_wait_a: assert property (psel && !penable |=> pready)
		else $error("pready late");
	rdy_single_a: assert property (pready |=> !pready)
		else $error("pready too long");
	err_with_rdy_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not idle");
	timed_set_a: assert property (wr && paddr == 8'h40 |=>
		(dac_timed & $past(pwdata[7:0])) == $past(pwdata[7:0]))
		else $error("timed select lost");
	immed_set_a: assert property (wr && paddr == 8'h44 |=>
		(dac_timed & $past(pwdata[7:0])) == 8'h00)
		else $error("immediate select lost");
	mode_hold_a: assert property (!wr |=> $stable(dac_timed))
		else $error("mode changed without write");
	value_hold_a: assert property (!wr && !update_pulse &&
		!(wave_valid && wave_ready) |=> $stable(dac_value))
		else $error("output moved without cause");
	ready_gap_a: assert property (wave_valid && wave_ready |=>
		!wave_ready)
		else $error("sample ready not dropped");
	irq_cause_a: assert property ($rose(irq) |->
		$past(cause) || $past(cause, 2) || $past(cause, 3))
		else $error("irq rose without cause");
endmodule : dumc_properties

bind dumc_update_ctrl dumc_properties #(.SEQ_DEPTH(SEQ_DEPTH)) chk (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .update_pulse, .fifo_prog_full_flag, .wave_valid, .wave_ready,
	.dac_value, .dac_timed, .irq);

// ---- verification/dac_update_mode_control_test.sv ----
// self-checking bench for the update-mode block
`timescale 1ns/1ps
module dac_update_mode_control_test import dumc_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
	logic update_pulse, fifo_prog_full_flag, wave_valid, wave_ready, irq;
	logic [7:0] paddr, dac_timed, m, k;
	logic [31:0] pwdata, prdata, rd;
	logic [11:0] wave_data, v0, v1;
	logic [11:0] ev[8];
	logic [11:0] s[3];
	logic [2:0] q[3] = '{3'h6, 3'h2, 3'h1};
	logic [95:0] dac_value;
	int n_errors = 0;
	int samples_checked = 0;
	dumc_update_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .update_pulse,
		.fifo_prog_full_flag, .wave_valid, .wave_data, .wave_ready,
		.dac_value, .dac_timed, .irq);
	// outputs read right after the edge are the values that edge sampled
	task tick;
		@(posedge pclk);
	endtask : tick
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [11:0] dac(input int n);
		return dac_value[12*n +: 12];
	endfunction : dac
	function automatic logic [7:0] mode(input logic [7:0] o, t, i);
		return (o | t) & ~i;
	endfunction : mode
	// holds the request until pready is sampled high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		tick;
		penable <= 1'b1;
		tick;
		while (pready !== 1'b1 && n < 20) begin
			tick;
			n++;
		end
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tick;
		if (n == 20) begin
			n_errors++;
			$display("ERROR %0t: apb timeout", $time);
		end
	endtask : apb
	task pulse;
		update_pulse <= 1'b1;
		tick;
		update_pulse <= 1'b0;
		tick;
	endtask : pulse
	// valid stands until ready is sampled with it, then one idle edge
	task send(input logic [11:0] d);
		int n;
		n = 0;
		wave_valid <= 1'b1;
		wave_data <= d;
		tick;
		while (wave_ready !== 1'b1 && n < 20) begin
			tick;
			n++;
		end
		wave_valid <= 1'b0;
		tick;
		if (n == 20) begin
			n_errors++;
			$display("ERROR %0t: sample timeout", $time);
		end
	endtask : send
	task end_sim;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// about 160 cycles expected; generous margin
	initial begin
		#200000;
		n_errors++;
		end_sim;
	end
	initial begin
		{presetn, psel, penable, pwrite, update_pulse} = '0;
		{fifo_prog_full_flag, wave_valid, wave_data, paddr, pwdata} = '0;
		rd = $urandom(5457);
		repeat (5) tick;
		presetn <= 1'b1;
		tick;
		chk(dac_timed, 0);
		apb(0, 8'h88, 0);
		chk(rd, 1);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			ev[i] = 12'($urandom);
			apb(1, 8'(4 * i), {20'h0, ev[i]});
			chk(dac(i), ev[i]);
		end
		$display("direct test done");
		m = 8'($urandom);
		k = 8'($urandom);
		apb(1, 8'h40, {24'h0, m});
		chk(dac_timed, mode(0, m, 0));
		apb(1, 8'h40, 0);
		chk(dac_timed, m);
		apb(1, 8'h44, {24'h0, k});
		chk(dac_timed, mode(m, 0, k));
		apb(1, 8'h44, 32'h0000_00ff);
		$display("mode test done");
		apb(1, 8'h40, 32'h0000_002a);
		apb(1, 8'h50, 32'h0000_0028);
		v0 = 12'($urandom);
		// distinct values so a wrong channel cannot match by luck
		v1 = ~v0;
		apb(1, 8'h0c, {20'h0, v0});
		apb(1, 8'h14, {20'h0, v1});
		apb(1, 8'h04, {20'h0, v1});
		chk(dac(3), ev[3]);
		pulse;
		chk(dac(3), v0);
		chk(dac(5), v1);
		chk(dac(1), ev[1]);
		apb(1, 8'h50, 32'h0000_0008);
		apb(1, 8'h14, {20'h0, v0});
		pulse;
		chk(dac(5), v1);
		$display("deferred test done");
		for (int i = 0; i < 3; i++) apb(1, 8'h54, {29'h0, q[i]});
		for (int i = 0; i < 3; i++) begin
			s[i] = 12'($urandom);
			send(s[i]);
		end
		pulse;
		for (int i = 0; i < 3; i++) chk(dac(q[i]), s[i]);
		apb(0, 8'h80, 0);
		chk(rd[23:16], 8'h46);
		apb(1, 8'h58, 32'h0000_0001);
		apb(0, 8'h80, 0);
		chk(rd[23:8], 16'h0008);
		apb(1, 8'h04, {20'h0, v1});
		pulse;
		chk(dac(1), s[2]);
		chk(wave_ready, 0);
		$display("sequence test done");
		apb(1, 8'h84, 32'h0000_0007);
		apb(1, 8'h58, 32'h0000_0002);
		fifo_prog_full_flag <= 1'b1;
		repeat (3) tick;
		chk(irq, 1);
		apb(1, 8'h88, 0);
		tick;
		chk(irq, 0);
		fifo_prog_full_flag <= 1'b0;
		apb(1, 8'h84, 32'h0000_0001);
		apb(1, 8'h88, 32'h0000_0001);
		tick;
		chk(irq, 0);
		$display("irq test done");
		apb(0, 8'hfc, 0);
		chk(perr, 1);
		chk(rd, 0);
		apb(1, 8'h42, 32'h0000_00ff);
		chk(perr, 1);
		chk(dac_timed, 8'h2a);
		$display("refusal test done");
		for (int i = 0; i < 9; i++) apb(1, 8'h54, {29'h0, 3'($urandom)});
		apb(0, 8'h80, 0);
		chk(rd[27:24], 8);
		apb(0, 8'h84, 0);
		chk(rd[1], 1);
		$display("overflow test done");
		end_sim;
	end
endmodule : dac_update_mode_control_test
